// File: conv_ctrl_pkg.sv
// Shared constants for the converter sequencing and input select block
package conv_ctrl_pkg;
  // Register offsets on the plain register port
  localparam logic [3:0] OFS_RESULT_HI = 4'h0;
  localparam logic [3:0] OFS_RESULT_LO = 4'h1;
  localparam logic [3:0] OFS_CONTROL_0 = 4'h2;
  localparam logic [3:0] OFS_CONTROL_1 = 4'h3;
  localparam logic [3:0] OFS_SHARE_LO = 4'h4;
  localparam logic [3:0] OFS_SHARE_HI = 4'h5;
  // Control 0 field positions
  localparam int C0_START = 7;
  localparam int C0_BUSY = 6;
  localparam int C0_ENABLE = 5;
  localparam int C0_FORMAT = 4;
  localparam int C0_CH_LSB = 0;
  // Control 1 field positions
  localparam int C1_SRC_LSB = 5;
  localparam int C1_REF_LSB = 3;
  localparam int C1_CK_LSB = 0;
  // Share high register field positions
  localparam int SH_CH_LSB = 0;
  localparam int SH_VREF = 2;
  // Reset values
  localparam logic [7:0] CONTROL_0_RST = 8'h00;
  localparam logic [7:0] CONTROL_1_RST = 8'h00;
  localparam logic [9:0] SHARE_RST = 10'h000;
  localparam logic [11:0] RESULT_RST = 12'h000;
  // Field codes
  localparam logic [1:0] REF_SUPPLY = 2'h1;
  localparam logic [2:0] SRC_INTERNAL = 3'h1;
  localparam logic [2:0] SRC_GND_FIRST = 3'h2;
  localparam logic [2:0] SRC_GND_LAST = 3'h4;
  localparam int NUM_CH = 10;
  localparam int RES_BITS = 12;
  // Timing in converter clock cycles
  localparam logic [3:0] SAMPLE_CYCLES = 4'h4;
  localparam logic [3:0] CONVERT_CYCLES = 4'hc;
  localparam logic [11:0] SAR_FIRST_TRIAL = 12'h800;
endpackage

// File: conv_clk_div.sv
// Power-of-two divider producing the converter clock enable
`timescale 1ns/1ps
module conv_clk_div (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_resetn,
  // Control
  input wire logic i_run,
  input wire logic i_restart,
  input wire logic [2:0] i_sel,
  // Enable pulse
  output logic o_tick
);
  logic [6:0] cnt_q;
  logic [6:0] cnt_d;
  logic tick_q;
  logic tick_d;
  logic [6:0] mask;

  always_comb begin
    mask = 7'(({7'h00, 1'b1} << i_sel) - 8'h01);
    cnt_d = cnt_q;
    tick_d = 1'b0;
    if (!i_run || i_restart) begin
      cnt_d = 7'h00;
    end else begin
      cnt_d = 7'(cnt_q + 7'h01);
      // Division by 2 to the power of the select code
      tick_d = ((cnt_q & mask) == mask);
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      cnt_q <= 7'h00;
      tick_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      tick_q <= tick_d;
    end
  end

  assign o_tick = tick_q;
endmodule

// File: adc_sequencing_and_input_select.sv
// Converter control: register file, input and reference routing, pin sharing, sequencing
`timescale 1ns/1ps
// Function
// - Reference from supply rail only for code 01, else from reference pin.
// - Pin selected as analog input loses all its other functions.
// - Pull-high resistor disconnected while pin is an analog input.
// - Port direction ignored while pin is an analog input.
// - Source codes 000 and 101-111 route the external channel selected.
// - Channel codes 0000-1001 connect analog inputs 0 to 9.
// - Channel codes 1010-1111 connect nothing; input floats.
// - Source code 001 routes internal twenty-times amplifier signal.
// - Source codes 010-100 tie converter input to ground.
// - Conversion starts after start bit goes low, high, then low again.
// - Busy flag is one from trigger until conversion completes.
// - Completion sets interrupt request and raises interrupt when enabled.
// - Converter clock is system clock divided by 1 to 128.
// - Analog circuitry powered exactly while the enable bit is high.
// - Four sampling then twelve conversion clock cycles per conversion.
// - Result left or right justified by format bit; unused bits zero.
// - Result registers hold their contents while converter is disabled.
module adc_sequencing_and_input_select (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_resetn,
  // Register port
  input wire logic [3:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  // Port logic requests for the shared pins
  input wire logic [9:0] i_port_oe,
  input wire logic [9:0] i_port_pull,
  input wire logic i_vref_port_oe,
  input wire logic i_vref_port_pull,
  // Shared pin control
  output logic [9:0] o_pin_analog,
  output logic [9:0] o_pin_oe,
  output logic [9:0] o_pin_pull,
  output logic [9:0] o_pin_dig_in_en,
  output logic o_vref_pin_analog,
  output logic o_vref_pin_oe,
  output logic o_vref_pin_pull,
  // Analog core
  input wire logic i_comp_above,
  output logic o_analog_power,
  output logic o_ref_supply,
  output logic o_ref_pin,
  output logic [9:0] o_ch_connect,
  output logic o_int_connect,
  output logic o_gnd_connect,
  output logic o_sampling,
  output logic [11:0] o_dac_code,
  // Interrupt controller
  input wire logic i_int_enable,
  output logic o_int_flag_set,
  output logic o_int_request
);
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_SAMPLE,
    ST_CONVERT
  } seq_state_t;

  // Extends a result into the two bytes per the justification bit
  function automatic logic [7:0] result_byte(input logic [11:0] res, input logic right,
                                             input logic high);
    logic [15:0] word;
    word = right ? {4'h0, res} : {res, 4'h0};
    result_byte = high ? word[15:8] : word[7:0];
  endfunction

  // Source codes that route an external channel
  function automatic logic is_external(input logic [2:0] src);
    is_external = (src == 3'h0) || (src > conv_ctrl_pkg::SRC_GND_LAST);
  endfunction

  // Control fields
  logic start_q;
  logic start_d;
  logic enable_q;
  logic enable_d;
  logic format_q;
  logic format_d;
  logic [3:0] chan_q;
  logic [3:0] chan_d;
  logic [2:0] src_q;
  logic [2:0] src_d;
  logic [1:0] ref_q;
  logic [1:0] ref_d;
  logic [2:0] ck_q;
  logic [2:0] ck_d;
  logic [9:0] share_q;
  logic [9:0] share_d;
  logic vref_share_q;
  logic vref_share_d;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  logic wr_c0;
  logic trigger;
  // Result and busy are read back by the register port, so they are declared here
  logic [11:0] result_q;
  logic [11:0] result_d;
  logic busy_q;
  logic busy_d;

  always_comb begin
    start_d = start_q;
    enable_d = enable_q;
    format_d = format_q;
    chan_d = chan_q;
    src_d = src_q;
    ref_d = ref_q;
    ck_d = ck_q;
    share_d = share_q;
    vref_share_d = vref_share_q;
    rdata_d = 8'h00;
    wr_c0 = i_wr && (i_addr == conv_ctrl_pkg::OFS_CONTROL_0);
    if (wr_c0) begin
      start_d = i_wdata[conv_ctrl_pkg::C0_START];
      enable_d = i_wdata[conv_ctrl_pkg::C0_ENABLE];
      format_d = i_wdata[conv_ctrl_pkg::C0_FORMAT];
      chan_d = i_wdata[conv_ctrl_pkg::C0_CH_LSB +: 4];
    end
    if (i_wr && (i_addr == conv_ctrl_pkg::OFS_CONTROL_1)) begin
      src_d = i_wdata[conv_ctrl_pkg::C1_SRC_LSB +: 3];
      ref_d = i_wdata[conv_ctrl_pkg::C1_REF_LSB +: 2];
      ck_d = i_wdata[conv_ctrl_pkg::C1_CK_LSB +: 3];
    end
    if (i_wr && (i_addr == conv_ctrl_pkg::OFS_SHARE_LO)) begin
      share_d[7:0] = i_wdata;
    end
    if (i_wr && (i_addr == conv_ctrl_pkg::OFS_SHARE_HI)) begin
      share_d[9:8] = i_wdata[conv_ctrl_pkg::SH_CH_LSB +: 2];
      vref_share_d = i_wdata[conv_ctrl_pkg::SH_VREF];
    end
    if (i_rd) begin
      case (i_addr)
        conv_ctrl_pkg::OFS_RESULT_HI: rdata_d = result_byte(result_q, format_q, 1'b1);
        conv_ctrl_pkg::OFS_RESULT_LO: rdata_d = result_byte(result_q, format_q, 1'b0);
        conv_ctrl_pkg::OFS_CONTROL_0: rdata_d = {start_q, busy_q, enable_q, format_q, chan_q};
        conv_ctrl_pkg::OFS_CONTROL_1: rdata_d = {src_q, ref_q, ck_q};
        conv_ctrl_pkg::OFS_SHARE_LO: rdata_d = share_q[7:0];
        conv_ctrl_pkg::OFS_SHARE_HI: rdata_d = {5'h00, vref_share_q, share_q[9:8]};
        default: rdata_d = 8'h00;
      endcase
    end
  end

  // Trigger is the falling write of a start bit that was high
  assign trigger = wr_c0 && start_q && !i_wdata[conv_ctrl_pkg::C0_START] &&
                   i_wdata[conv_ctrl_pkg::C0_ENABLE] && enable_q;

  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      start_q <= conv_ctrl_pkg::CONTROL_0_RST[conv_ctrl_pkg::C0_START];
      enable_q <= conv_ctrl_pkg::CONTROL_0_RST[conv_ctrl_pkg::C0_ENABLE];
      format_q <= conv_ctrl_pkg::CONTROL_0_RST[conv_ctrl_pkg::C0_FORMAT];
      chan_q <= conv_ctrl_pkg::CONTROL_0_RST[conv_ctrl_pkg::C0_CH_LSB +: 4];
      src_q <= conv_ctrl_pkg::CONTROL_1_RST[conv_ctrl_pkg::C1_SRC_LSB +: 3];
      ref_q <= conv_ctrl_pkg::CONTROL_1_RST[conv_ctrl_pkg::C1_REF_LSB +: 2];
      ck_q <= conv_ctrl_pkg::CONTROL_1_RST[conv_ctrl_pkg::C1_CK_LSB +: 3];
      share_q <= conv_ctrl_pkg::SHARE_RST;
      vref_share_q <= 1'b0;
      rdata_q <= 8'h00;
    end else begin
      start_q <= start_d;
      enable_q <= enable_d;
      format_q <= format_d;
      chan_q <= chan_d;
      src_q <= src_d;
      ref_q <= ref_d;
      ck_q <= ck_d;
      share_q <= share_d;
      vref_share_q <= vref_share_d;
      rdata_q <= rdata_d;
    end
  end

  // Sequencer
  seq_state_t state_q;
  seq_state_t state_d;
  logic [3:0] cnt_q;
  logic [3:0] cnt_d;
  logic [11:0] sar_q;
  logic [11:0] sar_d;
  logic done_q;
  logic done_d;
  logic [3:0] bit_idx;
  logic tick;

  conv_clk_div u_div (
    .i_clk(i_clk),
    .i_resetn(i_resetn),
    .i_run(enable_q),
    .i_restart(trigger),
    .i_sel(ck_q),
    .o_tick(tick)
  );

  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    sar_d = sar_q;
    result_d = result_q;
    busy_d = busy_q;
    done_d = 1'b0;
    bit_idx = 4'(4'hb - cnt_q);
    if (!enable_d) begin
      // Disabled: sequencer parked, result untouched
      state_d = ST_IDLE;
      busy_d = 1'b0;
    end else if (trigger) begin
      state_d = ST_SAMPLE;
      cnt_d = 4'h0;
      busy_d = 1'b1;
    end else if (start_q) begin
      // A high start bit holds the converter in reset
      state_d = ST_IDLE;
      busy_d = 1'b0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          busy_d = 1'b0;
        end
        ST_SAMPLE: begin
          if (tick) begin
            cnt_d = 4'(cnt_q + 4'h1);
            if (cnt_q == 4'(conv_ctrl_pkg::SAMPLE_CYCLES - 4'h1)) begin
              state_d = ST_CONVERT;
              cnt_d = 4'h0;
              sar_d = conv_ctrl_pkg::SAR_FIRST_TRIAL;
            end
          end
        end
        ST_CONVERT: begin
          if (tick) begin
            cnt_d = 4'(cnt_q + 4'h1);
            // One result bit resolved per converter clock
            if (!i_comp_above) begin
              sar_d[bit_idx] = 1'b0;
            end
            if (bit_idx != 4'h0) begin
              sar_d[4'(bit_idx - 4'h1)] = 1'b1;
            end
            if (cnt_q == 4'(conv_ctrl_pkg::CONVERT_CYCLES - 4'h1)) begin
              state_d = ST_IDLE;
              result_d = sar_d;
              busy_d = 1'b0;
              done_d = 1'b1;
            end
          end
        end
        default: begin
          state_d = ST_IDLE;
          busy_d = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      state_q <= ST_IDLE;
      cnt_q <= 4'h0;
      sar_q <= conv_ctrl_pkg::RESULT_RST;
      result_q <= conv_ctrl_pkg::RESULT_RST;
      busy_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      sar_q <= sar_d;
      result_q <= result_d;
      busy_q <= busy_d;
      done_q <= done_d;
    end
  end

  // Routing and pin sharing, registered so every output is a flip-flop
  logic [9:0] ch_conn_d;
  logic [9:0] ch_conn_q;
  logic int_conn_q;
  logic gnd_conn_q;
  logic ref_supply_q;
  logic ref_pin_q;
  logic [9:0] pin_oe_q;
  logic [9:0] pin_pull_q;
  logic [9:0] pin_in_q;
  logic vref_oe_q;
  logic vref_pull_q;
  logic power_q;
  logic sampling_q;
  logic int_req_q;

  always_comb begin
    ch_conn_d = 10'h000;
    // Codes above nine leave every channel open
    if (is_external(src_q) && (chan_q < 4'(conv_ctrl_pkg::NUM_CH))) begin
      ch_conn_d[chan_q] = 1'b1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      ch_conn_q <= 10'h000;
      int_conn_q <= 1'b0;
      gnd_conn_q <= 1'b0;
      ref_supply_q <= 1'b0;
      ref_pin_q <= 1'b1;
      pin_oe_q <= 10'h000;
      pin_pull_q <= 10'h000;
      pin_in_q <= 10'h000;
      vref_oe_q <= 1'b0;
      vref_pull_q <= 1'b0;
      power_q <= 1'b0;
      sampling_q <= 1'b0;
      int_req_q <= 1'b0;
    end else begin
      ch_conn_q <= ch_conn_d;
      int_conn_q <= (src_q == conv_ctrl_pkg::SRC_INTERNAL);
      gnd_conn_q <= (src_q >= conv_ctrl_pkg::SRC_GND_FIRST) &&
                    (src_q <= conv_ctrl_pkg::SRC_GND_LAST);
      ref_supply_q <= (ref_q == conv_ctrl_pkg::REF_SUPPLY);
      ref_pin_q <= (ref_q != conv_ctrl_pkg::REF_SUPPLY);
      pin_oe_q <= i_port_oe & ~share_d;
      pin_pull_q <= i_port_pull & ~share_d;
      pin_in_q <= ~share_d;
      vref_oe_q <= i_vref_port_oe & ~vref_share_d;
      vref_pull_q <= i_vref_port_pull & ~vref_share_d;
      power_q <= enable_d;
      sampling_q <= (state_d == ST_SAMPLE);
      int_req_q <= done_d && i_int_enable;
    end
  end

  assign o_rdata = rdata_q;
  assign o_pin_analog = share_q;
  assign o_pin_oe = pin_oe_q;
  assign o_pin_pull = pin_pull_q;
  assign o_pin_dig_in_en = pin_in_q;
  assign o_vref_pin_analog = vref_share_q;
  assign o_vref_pin_oe = vref_oe_q;
  assign o_vref_pin_pull = vref_pull_q;
  assign o_analog_power = power_q;
  assign o_ref_supply = ref_supply_q;
  assign o_ref_pin = ref_pin_q;
  assign o_ch_connect = ch_conn_q;
  assign o_int_connect = int_conn_q;
  assign o_gnd_connect = gnd_conn_q;
  assign o_sampling = sampling_q;
  assign o_dac_code = sar_q;
  assign o_int_flag_set = done_q;
  assign o_int_request = int_req_q;
endmodule

// File: conv_ctrl_chk.sv
// Port checker for the converter control block
`timescale 1ns/1ps
module conv_ctrl_chk (
  // Clock, reset and interrupt enable
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_int_enable,
  // Shared pins
  input wire logic [9:0] o_pin_analog,
  input wire logic [9:0] o_pin_oe,
  input wire logic [9:0] o_pin_pull,
  input wire logic [9:0] o_pin_dig_in_en,
  input wire logic o_vref_pin_analog,
  input wire logic o_vref_pin_oe,
  input wire logic o_vref_pin_pull,
  // Analog core and interrupt
  input wire logic o_analog_power,
  input wire logic o_ref_supply,
  input wire logic o_ref_pin,
  input wire logic [9:0] o_ch_connect,
  input wire logic o_int_connect,
  input wire logic o_gnd_connect,
  input wire logic o_sampling,
  input wire logic o_int_flag_set,
  input wire logic o_int_request
);
  default clocking @(posedge i_clk);
  endclocking
  default disable iff (!i_resetn);
  // The conversion phase can outlast a delay range, so its length is counted here
  logic done_pend_q;
  logic [11:0] done_wait_q;
  always_ff @(posedge i_clk) begin
    if (!i_resetn || !o_analog_power) begin
      done_pend_q <= 1'b0;
      done_wait_q <= 12'h000;
    end else if ($fell(o_sampling)) begin
      done_pend_q <= 1'b1;
      done_wait_q <= 12'h000;
    end else if (o_int_flag_set) begin
      done_pend_q <= 1'b0;
    end else if (done_pend_q) begin
      done_wait_q <= 12'(done_wait_q + 12'h001);
    end
  end
  property p_ref;
    o_ref_supply != o_ref_pin;
  endproperty
  a_ref: assert property (p_ref) else $error("both or no reference");
  property p_pin_off;
    (o_pin_analog & (o_pin_oe | o_pin_dig_in_en)) == 10'h000 &&
      !(o_vref_pin_analog && o_vref_pin_oe);
  endproperty
  a_pin_off: assert property (p_pin_off) else $error("analog pin keeps digital");
  property p_pull_off;
    (o_pin_analog & o_pin_pull) == 10'h000 && !(o_vref_pin_analog && o_vref_pin_pull);
  endproperty
  a_pull_off: assert property (p_pull_off) else $error("pull on analog pin");
  property p_route;
    $onehot0({o_ch_connect, o_int_connect, o_gnd_connect});
  endproperty
  a_route: assert property (p_route) else $error("two sources on input");
  // Aborts by clearing enable cut phases short, so power loss disables these two
  property p_sample;
    disable iff (!i_resetn || !o_analog_power) $rose(o_sampling) |-> o_sampling [*4];
  endproperty
  a_sample: assert property (p_sample) else $error("sampling too short");
  property p_done;
    done_pend_q |-> (done_wait_q < 12'h640) && (!o_int_flag_set || (done_wait_q >= 12'h00a));
  endproperty
  a_done: assert property (p_done) else $error("no completion");
  property p_pulse;
    o_int_flag_set |=> !o_int_flag_set;
  endproperty
  a_pulse: assert property (p_pulse) else $error("flag pulse too long");
  property p_req;
    o_int_flag_set |-> o_int_request == $past(i_int_enable);
  endproperty
  a_req: assert property (p_req) else $error("request not gated");
  property p_req_src;
    o_int_request |-> o_int_flag_set;
  endproperty
  a_req_src: assert property (p_req_src) else $error("stray request");
  property p_off;
    !o_analog_power && !$past(o_analog_power) |-> !o_sampling;
  endproperty
  a_off: assert property (p_off) else $error("sampling while off");
  c_done: cover property ($fell(o_sampling));
  c_req: cover property (o_int_request);
  c_int: cover property (o_int_connect);
endmodule

// File: conv_front_model.sv
// Analog front model: pin levels, amplifier signal and comparator
`timescale 1ns/1ps
module conv_front_model #(
  parameter logic [11:0] AMP_LEVEL = 12'h9c4
) (
  input wire logic i_clk,
  input wire logic [9:0] i_ch_connect,
  input wire logic i_int_connect,
  input wire logic i_gnd_connect,
  input wire logic [11:0] i_dac_code,
  output logic o_comp_above
);
  logic flip_q = 1'b0;
  logic [11:0] level;
  always_ff @(posedge i_clk) flip_q <= ~flip_q;
  always_comb begin
    level = 12'h000;
    for (int n = 0; n < 10; n++) if (i_ch_connect[n]) level = 12'h0a5 + 12'h173 * n[11:0];
    if (i_int_connect) level = AMP_LEVEL;
  end
  // A floating input gives no stable decision
  assign o_comp_above = ({i_ch_connect, i_int_connect, i_gnd_connect} == 12'h000) ? flip_q :
    (level >= i_dac_code);
endmodule

// File: testbench.sv
// Self-checking bench for the converter control block
`timescale 1ns/1ps
module testbench;
  localparam logic [11:0] AMP = 12'h9c4;
  localparam logic [3:0] RH = conv_ctrl_pkg::OFS_RESULT_HI;
  localparam logic [3:0] RL = conv_ctrl_pkg::OFS_RESULT_LO;
  localparam logic [3:0] C0 = conv_ctrl_pkg::OFS_CONTROL_0;
  localparam logic [3:0] C1 = conv_ctrl_pkg::OFS_CONTROL_1;
  logic i_clk = 1'b0;
  logic i_resetn = 1'b0;
  logic [3:0] i_addr = 4'h0;
  logic [7:0] i_wdata = 8'h00;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic [9:0] i_port_oe = 10'h2aa;
  logic [9:0] i_port_pull = 10'h3ff;
  logic i_vref_port_oe = 1'b1;
  logic i_vref_port_pull = 1'b1;
  logic i_int_enable = 1'b0;
  wire i_comp_above;
  wire [7:0] o_rdata;
  wire [9:0] o_pin_analog, o_pin_oe, o_pin_pull, o_pin_dig_in_en, o_ch_connect;
  wire o_vref_pin_analog, o_vref_pin_oe, o_vref_pin_pull, o_analog_power;
  wire o_ref_supply, o_ref_pin, o_int_connect, o_gnd_connect, o_sampling;
  wire o_int_flag_set, o_int_request;
  wire [11:0] o_dac_code;
  logic [7:0] rdv;
  logic [11:0] exp_v;
  int failures = 0;
  int compares = 0;
  int cyc = 0;
  int flags = 0;
  int reqs = 0;
  always #2 i_clk = ~i_clk;
  adc_sequencing_and_input_select dut_u (.i_clk, .i_resetn, .i_addr, .i_wdata, .i_wr, .i_rd,
    .o_rdata, .i_port_oe, .i_port_pull, .i_vref_port_oe, .i_vref_port_pull, .o_pin_analog,
    .o_pin_oe, .o_pin_pull, .o_pin_dig_in_en, .o_vref_pin_analog, .o_vref_pin_oe,
    .o_vref_pin_pull, .i_comp_above, .o_analog_power, .o_ref_supply, .o_ref_pin,
    .o_ch_connect, .o_int_connect, .o_gnd_connect, .o_sampling, .o_dac_code, .i_int_enable,
    .o_int_flag_set, .o_int_request);
  conv_front_model #(.AMP_LEVEL(AMP)) front_u (.i_clk, .i_ch_connect(o_ch_connect),
    .i_int_connect(o_int_connect), .i_gnd_connect(o_gnd_connect), .i_dac_code(o_dac_code),
    .o_comp_above(i_comp_above));
  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    flags <= flags + int'(o_int_flag_set);
    reqs <= reqs + int'(o_int_request);
    if (cyc == 20000) begin
      failures++;
      give_verdict;
    end
  end
  task automatic give_verdict;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic cmp(input logic [11:0] got, input logic [11:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_clk);
    i_wr <= 1'b0;
    @(posedge i_clk);
  endtask
  task automatic rd(input logic [3:0] a);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1;
    rdv = o_rdata;
    @(posedge i_clk);
  endtask
  task automatic rd_chk(input logic [3:0] a, input logic [7:0] exp);
    rd(a);
    cmp({4'h0, rdv}, {4'h0, exp}, "read");
  endtask
  task automatic settle;
    repeat (2) @(posedge i_clk);
    #1;
  endtask
  task automatic conv(input logic [2:0] s, input logic [3:0] c, input logic f,
    input logic [2:0] k);
    logic [11:0] v;
    int t0;
    int f0;
    int r0;
    int dt;
    v = (s == 3'h1) ? AMP : (s inside {[3'h2:3'h4]}) ? 12'h000 : 12'h0a5 + 12'h173 * c;
    i_int_enable <= f;
    if (s == 3'h1) wr(C0, {3'h5, f, c});
    wr(C1, {s, 2'h0, k});
    wr(C0, {3'h5, f, c});
    repeat (8) @(posedge i_clk);
    f0 = flags;
    r0 = reqs;
    wr(C0, {3'h1, f, c});
    t0 = cyc;
    rd(C0);
    cmp({11'h0, rdv[6]}, 12'h001, "busy");
    while (rdv[6] && cyc - t0 < 3000) rd(C0);
    dt = cyc - t0;
    cmp({11'h0, dt >= (16 << k) - 2 && dt <= (16 << k) + 8}, 12'h001, "time");
    repeat (3) @(posedge i_clk);
    cmp(12'(flags - f0), 12'h001, "flag");
    cmp(12'(reqs - r0), {11'h0, f}, "irq");
    rd_chk(RH, f ? {4'h0, v[11:8]} : v[11:4]);
    rd_chk(RL, f ? v[7:0] : {v[3:0], 4'h0});
    wr(C0, {3'h0, f, c});
  endtask
  initial begin
    repeat (12) @(posedge i_clk);
    i_resetn <= 1'b1;
    @(posedge i_clk);
    for (int a = 0; a < 7; a++) rd_chk((a < 6) ? a[3:0] : 4'hf, 8'h00);
    cmp({o_pin_dig_in_en, o_ref_supply, o_ref_pin}, 12'hffd, "reset pins");
    wr(RH, 8'hff);
    wr(C0, 8'h40);
    rd_chk(RH, 8'h00);
    rd_chk(C0, 8'h00);
    $display("test reset done");
    for (int r = 0; r < 4; r++) begin
      wr(C1, {3'h0, r[1:0], 3'h0});
      settle;
      cmp({10'h0, o_ref_supply, o_ref_pin}, (r == 1) ? 12'h002 : 12'h001, "ref");
    end
    $display("test reference done");
    wr(conv_ctrl_pkg::OFS_SHARE_LO, 8'h0f);
    wr(conv_ctrl_pkg::OFS_SHARE_HI, 8'h06);
    settle;
    cmp({2'h0, o_pin_analog}, 12'h20f, "analog");
    cmp({2'h0, o_pin_oe}, 12'h0a0, "oe");
    cmp({2'h0, o_pin_pull}, 12'h1f0, "pull");
    cmp({2'h0, o_pin_dig_in_en}, 12'h1f0, "din");
    cmp({9'h0, o_vref_pin_analog, o_vref_pin_oe, o_vref_pin_pull}, 12'h004, "vref");
    $display("test pins done");
    for (int s = 0; s < 8; s++) begin
      for (int c = 0; c < 16; c++) begin
        if (s == 1 && c < 10) continue;
        wr(C1, {s[2:0], 5'h00});
        wr(C0, {4'h2, c[3:0]});
        settle;
        exp_v = ((s == 0 || s > 4) && c < 10) ? 12'h001 << c : 12'h000;
        cmp({2'h0, o_ch_connect}, exp_v, "ch");
        exp_v = {10'h000, s == 1, s > 1 && s < 5};
        cmp({10'h0, o_int_connect, o_gnd_connect}, exp_v, "src");
      end
    end
    $display("test routing done");
    conv(3'h0, 4'h3, 1'b0, 3'h0);
    conv(3'h1, 4'ha, 1'b1, 3'h7);
    conv(3'h3, 4'hc, 1'b0, 3'h7);
    conv(3'h7, 4'h5, 1'b0, 3'h3);
    conv(3'h5, 4'h9, 1'b1, 3'h7);
    $display("test conversions done");
    wr(C0, 8'h90);
    wr(C0, 8'h10);
    rd_chk(C0, 8'h10);
    settle;
    cmp({11'h0, o_analog_power}, 12'h000, "power off");
    wr(C0, 8'hb0);
    settle;
    cmp({11'h0, o_analog_power}, 12'h001, "power on");
    repeat (8) @(posedge i_clk);
    wr(C0, 8'h30);
    repeat (600) @(posedge i_clk);
    wr(C0, 8'h10);
    // Wait past the time the cut conversion would have needed to finish
    repeat (1600) @(posedge i_clk);
    rd_chk(C0, 8'h10);
    rd_chk(RL, 8'hb0);
    rd_chk(RH, 8'h0d);
    $display("test disable done");
    give_verdict;
  end
endmodule
bind adc_sequencing_and_input_select conv_ctrl_chk chk_u (.i_clk, .i_resetn, .i_int_enable,
  .o_pin_analog, .o_pin_oe, .o_pin_pull, .o_pin_dig_in_en, .o_vref_pin_analog, .o_vref_pin_oe,
  .o_vref_pin_pull, .o_analog_power, .o_ref_supply, .o_ref_pin, .o_ch_connect, .o_int_connect,
  .o_gnd_connect, .o_sampling, .o_int_flag_set, .o_int_request);
